// ==== bench/smbus_host_model.sv ====
// SMBus host model that drives the two-wire bus of the register bank
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
    // Clock
    input wire logic ref_clk,
    // Two-wire bus, resolved data line in, driven clock and open-drain data pull out
    input wire logic sdaLine,
    output logic sclOut,
    output logic sdaLow
);
    // Each bus phase spans well over the device's pin filter latency
    localparam int PHASE = 8;
    logic curSda;
    initial begin
        sclOut = 1'b1;
        sdaLow = 1'b0;
        curSda = 1'b1;
    end
    // ********************************
    // Bus phases
    // ********************************
    task automatic setBus(input logic s, input logic d);
        sclOut <= s;
        sdaLow <= !d;
        curSda = d;
        repeat (PHASE) @(posedge ref_clk);
    endtask
    // Data only moves while the clock is low
    task automatic bitIo(input logic b, output logic seen);
        setBus(1'b0, curSda);
        setBus(1'b0, b);
        setBus(1'b1, b);
        seen = sdaLine;
    endtask
    task automatic startCond(input logic again);
        if (again) begin
            setBus(1'b0, 1'b1);
        end
        setBus(1'b1, 1'b1);
        setBus(1'b1, 1'b0);
    endtask
    task automatic stopCond();
        setBus(1'b0, curSda);
        setBus(1'b0, 1'b0);
        setBus(1'b1, 1'b0);
        setBus(1'b1, 1'b1);
    endtask
    task automatic byteIo(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitIo(tx[i], rx[i]);
        end
        bitIo(1'b1, s);
        ack = !s;
    endtask
    task automatic regWrite(input logic [7:0] adr, input logic [7:0] idx, input logic [7:0] d,
        output logic [2:0] acks);
        logic [7:0] r;
        startCond(1'b0);
        byteIo(adr, r, acks[2]);
        byteIo(idx, r, acks[1]);
        byteIo(d, r, acks[0]);
        stopCond();
    endtask
    task automatic regRead(input logic [7:0] adr, input logic [7:0] idx, output logic [7:0] d,
        output logic [2:0] acks);
        logic [7:0] r;
        logic s;
        startCond(1'b0);
        byteIo(adr, r, acks[2]);
        byteIo(idx, r, acks[1]);
        startCond(1'b1);
        byteIo(adr | 8'h01, r, acks[0]);
        for (int i = 7; i >= 0; i--) begin
            bitIo(1'b1, d[i]);
        end
        bitIo(1'b1, s);
        stopCond();
    endtask
endmodule // smbus_host_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// Testbench for the SMBus configuration and status register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import smbus_cfg_pkg::*;
    logic ref_clk, rst_n, ce, sclLine, hostLow, sdaOut, sdaOe, eeDone, pdPin, regCtrlEnable;
    logic [3:0] strap;
    logic [7:0] chanPowerDown, rdData, addrB;
    logic [2:0] acks;
    int fail_count = 0, total_checks = 0, cycles = 0;
    // Pull-up on the data line; any party pulling low wins
    wire logic sdaLine = !(hostLow || (sdaOe && !sdaOut));
    smbus_config_status_regs i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
        .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .strapIn(strap),
        .eepromDoneIn(eeDone), .powerDownPin(pdPin), .chanPowerDown(chanPowerDown),
        .regCtrlEnable(regCtrlEnable));
    smbus_host_model host (.ref_clk(ref_clk), .sdaLine(sdaLine), .sclOut(sclLine),
        .sdaLow(hostLow));
    // ********************************
    // Checking and bus tasks
    // ********************************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        host.regWrite(addrB, idx, d, acks);
        check("write acks", {5'h0, acks}, 8'h07);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string what);
        host.regRead(addrB, idx, rdData, acks);
        check("read acks", {5'h0, acks}, 8'h07);
        check(what, rdData, exp);
    endtask
    task automatic rdDefaults();
        for (int i = 1; i < 7; i++) begin
            rd(i[7:0], (i == 6) ? RST_REG_CTRL : RST_ZERO, "default");
        end
    endtask
    task automatic pdIs(input logic [7:0] exp);
        repeat (10) @(posedge ref_clk);
        check("chanPowerDown", chanPowerDown, exp);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = !ref_clk;
    end
    // Longest expected run is about 28000 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 80000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        strap = 4'h5;
        eeDone = 1'b1;
        pdPin = 1'b0;
        addrB = 8'hBA;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(IDX_OBSERVE, 8'h2C, "observe");
        rdDefaults();
        check("regCtrlEnable", {7'h0, regCtrlEnable}, 8'h00);
        host.regWrite(8'hB0, IDX_SPARE_A, 8'h5A, acks);
        check("foreign acks", {5'h0, acks}, 8'h00);
        rd(IDX_SPARE_A, RST_ZERO, "foreign");
        for (int i = 3; i < 6; i++) begin
            wr(i[7:0], 8'hA0 + i[7:0]);
            rd(i[7:0], 8'hA0 + i[7:0], "spare");
        end
        pdPin <= 1'b1;
        pdIs(ALL_POWERED_DOWN);
        wr(IDX_POWER_DOWN, 8'hA5);
        pdPin <= 1'b0;
        pdIs(8'h00);
        wr(IDX_OVERRIDE, 8'h01);
        pdPin <= 1'b1;
        pdIs(8'hA5);
        wr(IDX_POWER_DOWN, ALL_POWERED_DOWN);
        pdIs(ALL_POWERED_DOWN);
        wr(IDX_POWER_DOWN, 8'h3C);
        wr(IDX_REG_CTRL, 8'h18);
        check("regCtrlEnable", {7'h0, regCtrlEnable}, 8'h01);
        wr(IDX_OBSERVE, 8'h03);
        rd(IDX_OBSERVE, 8'h2C, "observe");
        rd(IDX_POWER_DOWN, 8'h3C, "blocked");
        rd(IDX_REG_CTRL, 8'h18, "blocked");
        wr(IDX_OBSERVE, 8'h01);
        rd(IDX_OBSERVE, 8'h2C, "observe");
        rdDefaults();
        pdIs(ALL_POWERED_DOWN);
        check("regCtrlEnable", {7'h0, regCtrlEnable}, 8'h00);
        // A low enable freezes the pin path; it moves once the enable returns
        ce <= 1'b0;
        pdPin <= 1'b0;
        pdIs(ALL_POWERED_DOWN);
        ce <= 1'b1;
        pdIs(8'h00);
        strap <= 4'h2;
        eeDone <= 1'b0;
        addrB = 8'hB4;
        repeat (10) @(posedge ref_clk);
        rd(IDX_OBSERVE, 8'h10, "observe");
        results();
    end
endmodule // tb_top
`default_nettype wire

// ==== design/smbus_config_status_regs.sv ====
// SMBus slave with the low configuration and status registers of the mux/buffer
//
// How it works
// - Reg 0 bits 6:3 show live straps
// - Reg 0 bit 2 shows EEPROM load done
// - Writing reg 0 bit 0 restores defaults
// - Reg 0 bit 1 blocks that soft reset
// - Reg 1 holds one power-down bit per channel
// - 0x00 enables all, 0xFF disables all
// - Override bit selects register or pin power-down
// - Reg 6 bit 3 enables register control; reset 0x10
// - Bus address 0xB0 plus twice the strap value
// - Write: address, index, one data byte, acks
// - Read: index write, restart, one byte, NACK
`timescale 1ns/1ps
`default_nettype none
module smbus_config_status_regs
    import smbus_cfg_pkg::*;
#(
    parameter int CHANNELS = 8,
    parameter int STRAPS = 4
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Two-wire bus, open drain
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Straps and status pins
    input wire logic [STRAPS-1:0] strapIn,
    input wire logic eepromDoneIn,
    input wire logic powerDownPin,
    // Controls to the datapath
    output logic [CHANNELS-1:0] chanPowerDown,
    output logic regCtrlEnable
);
    // ********************************
    // Pin synchronisers
    // ********************************
    // Three stages; a bit moves only when stages two and three agree
    pins_t s1_r, s2_r, s3_r, pinF_r;
    pins_t pinRaw;
    logic sclD_r, sdaD_r;
    assign pinRaw = '{scl: sclIn, sda: sdaIn, pdPin: powerDownPin, eeDone: eepromDoneIn,
        strap: strapIn};
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= PINS_IDLE;
            s2_r <= PINS_IDLE;
            s3_r <= PINS_IDLE;
            pinF_r <= PINS_IDLE;
            sclD_r <= 1'b1;
            sdaD_r <= 1'b1;
        end else if (ce) begin
            s1_r <= pinRaw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            pinF_r <= (pinF_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
            sclD_r <= pinF_r.scl;
            sdaD_r <= pinF_r.sda;
        end
    end
    logic sclRise, sclFall, startCond, stopCond;
    assign sclRise = ce & pinF_r.scl & ~sclD_r;
    assign sclFall = ce & ~pinF_r.scl & sclD_r;
    assign startCond = ce & pinF_r.scl & sclD_r & sdaD_r & ~pinF_r.sda;
    assign stopCond = ce & pinF_r.scl & sclD_r & ~sdaD_r & pinF_r.sda;
    // ********************************
    // Registers
    // ********************************
    logic obsRsvd_r;
    logic [CHANNELS-1:0] powerDown_r;
    logic [7:0] override_r, spareA_r, spareB_r, spareC_r, regCtrl_r;
    logic wrEn, softReset;
    logic [7:0] wrIdx_r, rxShift_r, rdData;
    // Blocking applies to the very write that carries it, so no state is held
    assign softReset = wrEn && wrIdx_r == IDX_OBSERVE && rxShift_r[OBS_SOFT_RESET_BIT]
        && !rxShift_r[OBS_BLOCK_RESET_BIT];
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            obsRsvd_r <= 1'b0;
            powerDown_r <= '0;
            override_r <= RST_ZERO;
            spareA_r <= RST_ZERO;
            spareB_r <= RST_ZERO;
            spareC_r <= RST_ZERO;
            regCtrl_r <= RST_REG_CTRL;
        end else if (softReset) begin
            obsRsvd_r <= 1'b0;
            powerDown_r <= '0;
            override_r <= RST_ZERO;
            spareA_r <= RST_ZERO;
            spareB_r <= RST_ZERO;
            spareC_r <= RST_ZERO;
            regCtrl_r <= RST_REG_CTRL;
        end else if (wrEn) begin
            unique case (wrIdx_r)
                IDX_OBSERVE: obsRsvd_r <= rxShift_r[OBS_RSVD_BIT];
                IDX_POWER_DOWN: powerDown_r <= rxShift_r[CHANNELS-1:0];
                IDX_OVERRIDE: override_r <= rxShift_r;
                IDX_SPARE_A: spareA_r <= rxShift_r;
                IDX_SPARE_B: spareB_r <= rxShift_r;
                IDX_SPARE_C: spareC_r <= rxShift_r;
                IDX_REG_CTRL: regCtrl_r <= rxShift_r;
                default: ;
            endcase
        end
    end
    // Self-clearing bits are never stored, so they always read zero
    always_comb begin
        rdData = RST_ZERO;
        unique case (wrIdx_r)
            IDX_OBSERVE: begin
                rdData[OBS_RSVD_BIT] = obsRsvd_r;
                rdData[OBS_STRAP_LSB +: STRAPS] = pinF_r.strap;
                rdData[OBS_EE_DONE_BIT] = pinF_r.eeDone;
            end
            IDX_POWER_DOWN: rdData[CHANNELS-1:0] = powerDown_r;
            IDX_OVERRIDE: rdData = override_r;
            IDX_SPARE_A: rdData = spareA_r;
            IDX_SPARE_B: rdData = spareB_r;
            IDX_SPARE_C: rdData = spareC_r;
            IDX_REG_CTRL: rdData = regCtrl_r;
            default: rdData = RST_ZERO;
        endcase
    end
    // ********************************
    // Outputs to the datapath
    // ********************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            chanPowerDown <= '0;
        end else if (ce) begin
            chanPowerDown <= override_r[OVR_PIN_BIT] ? powerDown_r
                : {CHANNELS{pinF_r.pdPin}};
        end
    end
    assign regCtrlEnable = regCtrl_r[RCE_ENABLE_BIT];
    // ********************************
    // Bus slave engine
    // ********************************
    bus_st_t state_r;
    logic [3:0] bitCnt_r;
    logic ackPhase_r, addrMatch;
    logic [7:0] txShift_r;
    logic [6:0] ownAddr;
    assign ownAddr = BUS_ADDR_BASE + 7'(pinF_r.strap);
    assign addrMatch = rxShift_r[7:1] == ownAddr;
    // Write lands as the eighth data bit closes, before the device acks it
    assign wrEn = ce && sclFall && state_r == ST_WDATA && bitCnt_r == BITS_PER_BYTE
        && !ackPhase_r;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            bitCnt_r <= BIT_CNT_ZERO;
            ackPhase_r <= 1'b0;
            rxShift_r <= RST_ZERO;
            txShift_r <= RST_ZERO;
            wrIdx_r <= RST_ZERO;
        end else if (startCond) begin
            state_r <= ST_ADDR;
            bitCnt_r <= BIT_CNT_ZERO;
            ackPhase_r <= 1'b0;
        end else if (stopCond) begin
            state_r <= ST_IDLE;
            ackPhase_r <= 1'b0;
        end else if (state_r != ST_IDLE && state_r != ST_IGNORE) begin
            if (sclRise) begin
                if (!ackPhase_r) begin
                    bitCnt_r <= bitCnt_r + BIT_CNT_ONE;
                    rxShift_r <= {rxShift_r[6:0], pinF_r.sda};
                end else if (state_r == ST_RDATA && pinF_r.sda) begin
                    state_r <= ST_IGNORE;
                end
            end else if (sclFall) begin
                if (!ackPhase_r && bitCnt_r == BITS_PER_BYTE) begin
                    ackPhase_r <= 1'b1;
                    if (state_r == ST_ADDR && !addrMatch) begin
                        state_r <= ST_IGNORE;
                    end
                end else if (ackPhase_r) begin
                    ackPhase_r <= 1'b0;
                    bitCnt_r <= BIT_CNT_ZERO;
                    unique case (state_r)
                        ST_ADDR: begin
                            state_r <= rxShift_r[0] ? ST_RDATA : ST_INDEX;
                            txShift_r <= rdData;
                        end
                        ST_INDEX: begin
                            wrIdx_r <= rxShift_r;
                            state_r <= ST_WDATA;
                        end
                        ST_WDATA: state_r <= ST_IGNORE;
                        ST_RDATA: txShift_r <= rdData;
                        default: ;
                    endcase
                end else if (state_r == ST_RDATA && bitCnt_r != BIT_CNT_ZERO) begin
                    txShift_r <= {txShift_r[6:0], 1'b0};
                end
            end
        end
    end
    always_comb begin
        sdaOe = 1'b0;
        if (state_r == ST_RDATA) begin
            sdaOe = !ackPhase_r && !txShift_r[7];
        end else if (state_r == ST_ADDR || state_r == ST_INDEX || state_r == ST_WDATA) begin
            sdaOe = ackPhase_r;
        end
    end
    assign sdaOut = 1'b0;
    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    AST_STRAP_OBS: assert property ((wrIdx_r == IDX_OBSERVE) |->
        rdData[OBS_STRAP_LSB +: STRAPS] == pinF_r.strap)
        else $error("strap field does not follow the straps");
    AST_EE_DONE: assert property ((wrIdx_r == IDX_OBSERVE) |->
        rdData[OBS_EE_DONE_BIT] == pinF_r.eeDone)
        else $error("load-done bit does not follow its pin");
    AST_SOFT_RESET: assert property (softReset |=>
        powerDown_r == '0 && override_r == RST_ZERO && regCtrl_r == RST_REG_CTRL)
        else $error("soft reset left a register changed");
    AST_BLOCK_RESET: assert property ((wrEn && wrIdx_r == IDX_OBSERVE
        && rxShift_r[OBS_BLOCK_RESET_BIT]) |=> $stable(powerDown_r) && $stable(regCtrl_r))
        else $error("blocked soft reset still reset registers");
    AST_SELF_CLEAR: assert property ((wrIdx_r == IDX_OBSERVE) |->
        rdData[OBS_BLOCK_RESET_BIT:OBS_SOFT_RESET_BIT] == 2'b00)
        else $error("self-clearing bits read back as one");
    AST_PD_SELECT: assert property (ce |=> chanPowerDown ==
        ($past(override_r[OVR_PIN_BIT]) ? $past(powerDown_r) : {CHANNELS{$past(pinF_r.pdPin)}}))
        else $error("power-down source selection wrong");
    AST_PD_ALL_OFF: assert property ((ce && !override_r[OVR_PIN_BIT] && pinF_r.pdPin) |=>
        chanPowerDown == ALL_POWERED_DOWN[CHANNELS-1:0])
        else $error("pin power-down did not disable every channel");
    AST_REG_CTRL: assert property ((wrEn && !softReset && wrIdx_r == IDX_REG_CTRL) |=>
        regCtrlEnable == $past(rxShift_r[RCE_ENABLE_BIT]))
        else $error("register-control enable does not follow the written bit");
    AST_ADDR_ACK: assert property ((state_r == ST_ADDR && sclFall && !ackPhase_r
        && bitCnt_r == BITS_PER_BYTE) |=> sdaOe == $past(addrMatch))
        else $error("address acknowledge does not match address compare");
    AST_READ_BIT: assert property ((state_r == ST_RDATA && !ackPhase_r) |->
        sdaOe == !txShift_r[7])
        else $error("read data bit not driven correctly");
    AST_SPARE: assert property ((wrEn && !softReset && wrIdx_r == IDX_SPARE_A) |=>
        spareA_r == $past(rxShift_r))
        else $error("spare register did not store the written byte");
    AST_WRITE_ACK: assert property (wrEn |=> sdaOe [*1] ##0 ackPhase_r)
        else $error("data byte not acknowledged");
    AST_PD_WRITE: assert property ((wrEn && wrIdx_r == IDX_POWER_DOWN) |=>
        powerDown_r == $past(rxShift_r[CHANNELS-1:0]))
        else $error("power-down register did not store the written byte");
    // ********************************
    // Bus engine checks
    // ********************************
    // A start always clears the engine, whatever state a cut frame left behind
    AST_START: assert property (startCond |=>
        state_r == ST_ADDR && bitCnt_r == BIT_CNT_ZERO && !sdaOe)
        else $error("start condition did not restart the engine");
    AST_STOP: assert property (stopCond |=> state_r == ST_IDLE && !sdaOe)
        else $error("stop condition did not release the bus");
    AST_BIT_COUNT: assert property ((state_r != ST_IDLE && state_r != ST_IGNORE
        && sclRise && !ackPhase_r) |=> bitCnt_r == $past(bitCnt_r) + BIT_CNT_ONE)
        else $error("bit counter did not advance on a clock rise");
    AST_BIT_BOUND: assert property (bitCnt_r <= BITS_PER_BYTE)
        else $error("bit counter ran past one byte");
    AST_INDEX_LATCH: assert property ((state_r == ST_INDEX && ackPhase_r && sclFall) |=>
        wrIdx_r == $past(rxShift_r) && state_r == ST_WDATA)
        else $error("register index not latched after its acknowledge");
    AST_ACK_RELEASE: assert property ((ackPhase_r && sclFall && state_r != ST_IDLE
        && state_r != ST_IGNORE) |=> !ackPhase_r && bitCnt_r == BIT_CNT_ZERO)
        else $error("acknowledge not released at the next clock fall");
    // Only one data byte per write; a further byte must see no acknowledge
    AST_SECOND_BYTE: assert property ((state_r == ST_WDATA && ackPhase_r && sclFall) |=>
        state_r == ST_IGNORE && !sdaOe)
        else $error("second data byte was accepted");
    AST_READ_LOAD: assert property ((state_r == ST_ADDR && ackPhase_r && sclFall
        && rxShift_r[0]) |=> state_r == ST_RDATA && txShift_r == $past(rdData))
        else $error("read data not loaded after the read address");
    AST_DATA_SHIFT: assert property ((state_r == ST_RDATA && !ackPhase_r && sclFall
        && bitCnt_r != BIT_CNT_ZERO && bitCnt_r != BITS_PER_BYTE)
        |=> txShift_r == {$past(txShift_r[6:0]), 1'b0})
        else $error("read data did not advance one bit");
    AST_HOST_NACK: assert property ((state_r == ST_RDATA && ackPhase_r && sclRise
        && pinF_r.sda) |=> state_r == ST_IGNORE && !sdaOe)
        else $error("host not-acknowledge did not end the read");
    // ********************************
    // Pin filter and clock enable checks
    // ********************************
    AST_FILTER: assert property ((ce && s2_r == s3_r) |=> pinF_r == $past(s3_r))
        else $error("filtered pins did not take agreeing stages");
    // A low enable must hold everything, synchronisers included
    AST_CE_FREEZE: assert property (!ce |=> $stable(pinF_r) && $stable(state_r)
        && $stable(bitCnt_r) && $stable(powerDown_r) && $stable(chanPowerDown))
        else $error("state moved while the clock enable was low");
endmodule // smbus_config_status_regs
`default_nettype wire

// ==== pkg/smbus_cfg_pkg.sv ====
// Constants and carrier types for the SMBus configuration and status register bank
package smbus_cfg_pkg;
    // ********************************
    // Register indices
    // ********************************
    localparam logic [7:0] IDX_OBSERVE = 8'h00;
    localparam logic [7:0] IDX_POWER_DOWN = 8'h01;
    localparam logic [7:0] IDX_OVERRIDE = 8'h02;
    localparam logic [7:0] IDX_SPARE_A = 8'h03;
    localparam logic [7:0] IDX_SPARE_B = 8'h04;
    localparam logic [7:0] IDX_SPARE_C = 8'h05;
    localparam logic [7:0] IDX_REG_CTRL = 8'h06;
    // ********************************
    // Field positions
    // ********************************
    localparam int OBS_SOFT_RESET_BIT = 0;
    localparam int OBS_BLOCK_RESET_BIT = 1;
    localparam int OBS_EE_DONE_BIT = 2;
    localparam int OBS_STRAP_LSB = 3;
    localparam int OBS_RSVD_BIT = 7;
    localparam int OVR_PIN_BIT = 0;
    localparam int RCE_ENABLE_BIT = 3;
    // ********************************
    // Reset values and the all-off power-down pattern
    // ********************************
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_REG_CTRL = 8'h10;
    localparam logic [7:0] ALL_POWERED_DOWN = 8'hFF;
    // ********************************
    // Bus framing
    // ********************************
    localparam logic [6:0] BUS_ADDR_BASE = 7'h58;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
    localparam logic [3:0] BIT_CNT_ONE = 4'h1;
    // Pins gathered for synchronisation
    typedef struct packed {
        logic scl;
        logic sda;
        logic pdPin;
        logic eeDone;
        logic [3:0] strap;
    } pins_t;
    localparam pins_t PINS_IDLE = '{scl: 1'b1, sda: 1'b1, pdPin: 1'b0, eeDone: 1'b0,
        strap: 4'h0};
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_INDEX, ST_WDATA, ST_RDATA, ST_IGNORE} bus_st_t;
endpackage
